// >>> io_irq_defs.vh
`ifndef IO_IRQ_DEFS_VH
`define IO_IRQ_DEFS_VH

// ============================================================
// channel operating modes
`define MODE_ALARM        2'h0
`define MODE_COUNTER      2'h1
`define MODE_FREQ         2'h2
`define MODE_OFF          2'h3

// ============================================================
// event byte field positions
`define EVB_GATE_OPEN     0
`define EVB_GATE_CLOSE    1
`define EVB_OVF_UNF       2
`define EVB_CMP_HIT       3
`define EVB_LATCH         4
`define EVB_MEAS_END      0

// ============================================================
// diagnostic cause bits
`define DIAG_LOST         0
`define DIAG_OUT_FEED     1
`define DIAG_IN_FEED      2
`define DIAG_SHORT        3
`define DIAG_W            4

// ============================================================
// handler-visible layout and reset values
`define EVT_BYTE_W        8
`define EVT_WORD_W        32
`define LOCAL_BASE_WORD   6
`define LOCAL_EVT_DWORD   8
`define BASE_ADDR_W       16
`define ZERO_BYTE         8'h00
`define ZERO_WORD         32'h0000_0000
`define ZERO_DIAG         4'h0
`define ZERO_CH           4'h0
`define ZERO_IN           16'h0000
`define ZERO_BASE         16'h0000

`endif

// >>> event_byte_format.v
`timescale 1ns/1ps
`default_nettype none
`include "io_irq_defs.vh"

// ============================================================
// one channel's event byte laid out for the channel's mode
module event_byte_format
#(
  parameter HAS_ALARM = 1,
  parameter HAS_GATE  = 0
)
(
  input  wire [1:0] mode,
  input  wire [7:0] alarm_edges,
  input  wire       ovf_unf,
  input  wire       cmp_hit,
  input  wire       gate_open,
  input  wire       gate_close,
  input  wire       latch_new,
  input  wire       meas_end,
  output reg  [7:0] evt_byte
);

  always @*
  begin
    evt_byte = `ZERO_BYTE;
    case (mode)
      `MODE_ALARM:
      begin
        // channels without alarm inputs keep the byte reserved as zero
        if (HAS_ALARM != 0)
          evt_byte = alarm_edges;
      end
      `MODE_COUNTER:
      begin
        evt_byte[`EVB_OVF_UNF] = ovf_unf;
        evt_byte[`EVB_CMP_HIT] = cmp_hit;
        if (HAS_GATE != 0)
        begin
          evt_byte[`EVB_GATE_OPEN]  = gate_open;
          evt_byte[`EVB_GATE_CLOSE] = gate_close;
          evt_byte[`EVB_LATCH]      = latch_new;
        end
      end
      `MODE_FREQ:
        evt_byte[`EVB_MEAS_END] = meas_end;
      default:
        evt_byte = `ZERO_BYTE;
    endcase
  end

endmodule // event_byte_format

`default_nettype wire

// >>> io_process_interrupt_event_word.v
`timescale 1ns/1ps
`default_nettype none
`include "io_irq_defs.vh"

// Behaviour
// - process interrupts only under combined diagnostics+process selection
// - triggers: alarm edge, compare, overflow, underflow, gates
// - diagnostics: lost interrupt, both feeds, output short
// - handler gets base address and event word
// - each event byte follows its channel's mode
// - alarm mode: byte 8 bit n is input 0.n
// - alarm mode: byte 9 is inputs 1.n; 10,11 reserved
// - counter mode bytes 8-10: bit2 over/underflow, bit3 compare
// - byte 11: gate open/close, wrap, compare, latch
// - frequency mode: bit 0 ends integration time
// - repeat event while handled raises lost diagnostic
module io_process_interrupt_event_word
#(
  parameter [15:0] BASE_ADDR = 16'h0000
)
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        irq_select_combined,
  input  wire        diag_enable,
  input  wire [3:0]  chan_irq_en,
  input  wire [7:0]  chan_mode,
  input  wire [15:0] alarm_in,
  input  wire [15:0] alarm_rise_en,
  input  wire [15:0] alarm_fall_en,
  input  wire [3:0]  cnt_cmp_hit,
  input  wire [3:0]  cnt_overflow,
  input  wire [3:0]  cnt_underflow,
  input  wire        hardware_gate,
  input  wire        software_gate,
  input  wire        cnt3_latch_new,
  input  wire [3:0]  meas_end,
  input  wire        output_power_feed_ok,
  input  wire        input_power_feed_ok,
  input  wire        do_short_overload,
  input  wire        proc_ack,
  input  wire        diag_ack,
  output reg         proc_irq_q,
  output reg  [31:0] event_word_q,
  output reg  [15:0] base_addr_q,
  output reg         diag_irq_q,
  output reg  [3:0]  diag_cause_q
);

  // ============================================================
  // edge helpers
  function edge_hit;
    input prev;
    input cur;
    input rise_en;
    input fall_en;
    begin
      edge_hit = (rise_en & ~prev & cur) | (fall_en & prev & ~cur);
    end
  endfunction

  function fault_rise;
    input ok_prev;
    input ok_cur;
    begin
      fault_rise = ok_prev & ~ok_cur;
    end
  endfunction

  // ============================================================
  // previous-sample registers and pending event word
  reg  [15:0] alarm_prev_q;
  reg         hardware_gate_prev_q;
  reg         out_feed_prev_q;
  reg         in_feed_prev_q;
  reg         short_prev_q;
  reg  [31:0] pend_word_q;

  wire [15:0] alarm_edges;
  wire        gate_open_evt;
  wire        gate_close_evt;
  wire [31:0] raw_word;
  wire [31:0] chan_mask;
  wire [31:0] new_word;
  wire        lost_evt;
  wire [3:0]  diag_evt;
  wire        take_ack;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_alarm
      assign alarm_edges[gi] = edge_hit(alarm_prev_q[gi], alarm_in[gi],
                                        alarm_rise_en[gi], alarm_fall_en[gi]);
    end
  endgenerate

  // gate events count only while the software gate stands open
  assign gate_open_evt  = software_gate & ~hardware_gate_prev_q & hardware_gate;
  assign gate_close_evt = software_gate & hardware_gate_prev_q & ~hardware_gate;

  // ============================================================
  // per-channel formatting
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_chan
      event_byte_format
      #(
        .HAS_ALARM ((gi < 2) ? 1 : 0),
        .HAS_GATE  ((gi == 3) ? 1 : 0)
      )
      u_fmt
      (
        .mode        (chan_mode[2*gi+1:2*gi]),
        .alarm_edges ((gi < 2) ? alarm_edges[8*(gi%2)+7:8*(gi%2)] : `ZERO_BYTE),
        .ovf_unf     (cnt_overflow[gi] | cnt_underflow[gi]),
        .cmp_hit     (cnt_cmp_hit[gi]),
        .gate_open   (gate_open_evt),
        .gate_close  (gate_close_evt),
        .latch_new   (cnt3_latch_new),
        .meas_end    (meas_end[gi]),
        .evt_byte    (raw_word[8*gi+7:8*gi])
      );
      assign chan_mask[8*gi+7:8*gi] = {`EVT_BYTE_W{chan_irq_en[gi]}};
    end
  endgenerate

  // whole word is suppressed unless the irq_select_combined input is set
  assign new_word = irq_select_combined ? (raw_word & chan_mask) : `ZERO_WORD;

  assign take_ack = proc_ack & proc_irq_q;

  // a repeat of an event that the handler still holds cannot be queued
  assign lost_evt = proc_irq_q & ~take_ack & |(new_word & event_word_q);

  assign diag_evt[`DIAG_LOST]     = lost_evt;
  assign diag_evt[`DIAG_OUT_FEED] = fault_rise(out_feed_prev_q, output_power_feed_ok);
  assign diag_evt[`DIAG_IN_FEED]  = fault_rise(in_feed_prev_q, input_power_feed_ok);
  assign diag_evt[`DIAG_SHORT]    = ~short_prev_q & do_short_overload;

  // ============================================================
  // sampling of inputs
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      alarm_prev_q    <= `ZERO_IN;
      hardware_gate_prev_q  <= 1'b0;
      out_feed_prev_q <= 1'b0;
      in_feed_prev_q  <= 1'b0;
      short_prev_q    <= 1'b0;
    end
    else if (ce)
    begin
      alarm_prev_q    <= alarm_in;
      hardware_gate_prev_q  <= hardware_gate;
      out_feed_prev_q <= output_power_feed_ok;
      in_feed_prev_q  <= input_power_feed_ok;
      short_prev_q    <= do_short_overload;
    end
  end

  // ============================================================
  // process interrupt delivery
  // events arriving while the handler runs, except repeats of bits held in
  // event_word_q, wait in pend_word_q and are
  // delivered as one further interrupt after the acknowledge
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      proc_irq_q   <= 1'b0;
      event_word_q <= `ZERO_WORD;
      pend_word_q  <= `ZERO_WORD;
      base_addr_q  <= `ZERO_BASE;
    end
    else if (ce)
    begin
      if (!proc_irq_q)
      begin
        if (|(new_word | pend_word_q))
        begin
          proc_irq_q   <= 1'b1;
          event_word_q <= new_word | pend_word_q;
          base_addr_q  <= BASE_ADDR;
          pend_word_q  <= `ZERO_WORD;
        end
      end
      else if (take_ack)
      begin
        // events in the acknowledge cycle are not lost
        if (|(new_word | pend_word_q))
        begin
          event_word_q <= new_word | pend_word_q;
          pend_word_q  <= `ZERO_WORD;
        end
        else
        begin
          proc_irq_q   <= 1'b0;
          event_word_q <= `ZERO_WORD;
        end
      end
      else
        pend_word_q <= pend_word_q | (new_word & ~event_word_q);
    end
  end

  // ============================================================
  // diagnostic interrupt
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      diag_irq_q   <= 1'b0;
      diag_cause_q <= `ZERO_DIAG;
    end
    else if (ce)
    begin
      if (diag_enable && (|diag_evt))
      begin
        // set wins over a clear in the same cycle
        diag_irq_q   <= 1'b1;
        diag_cause_q <= (diag_ack ? `ZERO_DIAG : diag_cause_q) | diag_evt;
      end
      else if (diag_ack)
      begin
        diag_irq_q   <= 1'b0;
        diag_cause_q <= `ZERO_DIAG;
      end
    end
  end

endmodule // io_process_interrupt_event_word

`default_nettype wire

// >>> io_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks on event word and diagnostics
module io_irq_monitor #(parameter [15:0] BASE_ADDR = 16'h0000) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        irq_select_combined,
  input wire logic        diag_enable,
  input wire logic [3:0]  chan_irq_en,
  input wire logic [7:0]  chan_mode,
  input wire logic [3:0]  cnt_cmp_hit,
  input wire logic [3:0]  cnt_overflow,
  input wire logic        cnt3_latch_new,
  input wire logic [3:0]  meas_end,
  input wire logic        output_power_feed_ok,
  input wire logic        proc_irq_q,
  input wire logic [31:0] event_word_q,
  input wire logic [15:0] base_addr_q,
  input wire logic        diag_irq_q,
  input wire logic [3:0]  diag_cause_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // an idle request path gives a fresh word one cycle later, as does an acknowledge cycle with events
  wire go = ce && irq_select_combined && !proc_irq_q;
  no_select_irq_a:
    assert property (ce && !irq_select_combined && !proc_irq_q |=> !proc_irq_q) else $error("irq unselected");
  cmp_bit_a:
    assert property (go && chan_mode[1:0] == 2'h1 && chan_irq_en[0] && cnt_cmp_hit[0]
      |=> proc_irq_q && event_word_q[3])
    else $error("cmp bit");
  wrap_bit_a:
    assert property (go && chan_mode[3:2] == 2'h1 && chan_irq_en[1] && cnt_overflow[1] |=> event_word_q[10])
    else $error("wrap bit");
  meas_end_a:
    assert property (go && chan_mode[7:6] == 2'h2 && chan_irq_en[3] && meas_end[3] |=> event_word_q[24])
    else $error("meas bit");
  latch_bit_a:
    assert property (go && chan_mode[7:6] == 2'h1 && chan_irq_en[3] && cnt3_latch_new |=> event_word_q[28])
    else $error("latch bit");
  meas_ch0_a:
    assert property (go && chan_mode[1:0] == 2'h2 && chan_irq_en[0] && meas_end[0] |=> event_word_q[0])
    else $error("meas ch0");
  base_addr_a:
    assert property (proc_irq_q |-> base_addr_q == BASE_ADDR) else $error("base addr");
  feed_diag_a:
    assert property (ce && diag_enable && $past(ce) && $past(rstn) && $fell(output_power_feed_ok)
      |=> diag_irq_q && diag_cause_q[1]) else $error("feed diag");
endmodule // io_irq_monitor
bind io_process_interrupt_event_word io_irq_monitor #(.BASE_ADDR(BASE_ADDR)) mon (.*);
`default_nettype wire

// >>> cpu_handler.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// user handler: acks each request lat+1 cycles after it rises
module cpu_handler (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] lat,
  input  wire logic       proc_irq_q,
  input  wire logic       diag_irq_q,
  output logic            proc_ack,
  output logic            diag_ack
);
  logic [3:0] pc, dc;
  always @(posedge clk)
  begin
    pc <= (!rstn || !proc_irq_q || proc_ack) ? 4'h0 : pc + 4'h1;
    dc <= (!rstn || !diag_irq_q || diag_ack) ? 4'h0 : dc + 4'h1;
    proc_ack <= #1 rstn && proc_irq_q && !proc_ack && pc == lat;
    diag_ack <= #1 rstn && diag_irq_q && !diag_ack && dc == lat;
  end
endmodule // cpu_handler
`default_nettype wire

// >>> io_process_interrupt_event_word_tb.sv
`timescale 1ns/1ps
`default_nettype none
module io_process_interrupt_event_word_tb;
  logic        clk, rstn, ce, irq_select_combined, diag_enable, hardware_gate, software_gate, do_short_overload;
  logic        cnt3_latch_new, output_power_feed_ok, input_power_feed_ok, proc_ack, diag_ack, proc_irq_q, diag_irq_q;
  logic [3:0]  chan_irq_en, cnt_cmp_hit, cnt_overflow, cnt_underflow, meas_end, diag_cause_q, lat;
  logic [7:0]  chan_mode;
  logic [15:0] alarm_in, alarm_rise_en, alarm_fall_en, base_addr_q;
  logic [31:0] event_word_q;
  integer      mismatches, comparisons, cycles, seed, i, k, ch, b;

  io_process_interrupt_event_word #(.BASE_ADDR(16'h1A2C)) DUT (.*);
  cpu_handler hdl (.clk(clk), .rstn(rstn), .lat(lat), .proc_irq_q(proc_irq_q), .diag_irq_q(diag_irq_q),
                   .proc_ack(proc_ack), .diag_ack(diag_ack));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end

  function automatic [31:0] expw(input integer k, ch, b, input logic hw);
    expw = (k == 0 ? 32'h1 << b : k == 1 ? 32'h8 : k < 4 ? 32'h4 : k == 4 ? 32'h1 : k == 7 ? 32'h10
            : hw ? 32'h1 : 32'h2) << (8 * ch);
  endfunction

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  // pulses set by the caller are taken at this edge, then dropped
  task fire;
  begin
    @(posedge clk);
    #1 {cnt_cmp_hit, cnt_overflow, cnt_underflow, meas_end, cnt3_latch_new} = '0;
  end
  endtask

  task idle;
  begin
    while ((proc_irq_q | diag_irq_q) !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
  end
  endtask

  task report_and_stop;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  initial
  begin
    {rstn, irq_select_combined, cnt_cmp_hit, cnt_overflow, cnt_underflow, meas_end, cnt3_latch_new} = '0;
    {alarm_in, hardware_gate, do_short_overload, chan_mode} = '0;
    {ce, diag_enable, software_gate, output_power_feed_ok, input_power_feed_ok, alarm_rise_en, alarm_fall_en} = '1;
    chan_irq_en = 4'hF;
    lat = 4'h2;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    seed = 24224;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    chan_mode = 8'h55;
    cnt_cmp_hit = 4'h1;
    fire;
    chk("unselected", 0, proc_irq_q);
    irq_select_combined = 1'b1;
    chan_irq_en = 4'hE;
    @(posedge clk) #1 cnt_cmp_hit = 4'h1;
    fire;
    chk("masked", 0, proc_irq_q);
    chan_irq_en = 4'hF;
    @(posedge clk) #1 cnt_cmp_hit = 4'hF;
    cnt3_latch_new = 1'b1;
    fire;
    chk("merged", 32'h18080808, event_word_q);
    idle;
    lat = 4'h8;
    cnt_cmp_hit = 4'h1;
    fire;
    @(posedge clk) #1 cnt_cmp_hit = 4'h1;
    fire;
    chk("lost", 5'h11, {diag_irq_q, diag_cause_q});
    chk("kept", 32'h8, event_word_q);
    idle;
    {output_power_feed_ok, input_power_feed_ok, do_short_overload} = 3'b001;
    fire;
    chk("diag", 5'h1E, {diag_irq_q, diag_cause_q});
    {output_power_feed_ok, input_power_feed_ok, do_short_overload} = 3'b110;
    idle;
    // another channel's event while busy waits and follows the acknowledge
    cnt_cmp_hit = 4'h1;
    fire;
    @(posedge clk) #1 cnt_overflow = 4'h2;
    fire;
    chk("no lost", 0, diag_irq_q);
    while (event_word_q === 32'h8)
    begin
      @(posedge clk);
      #1;
    end
    chk("pending", 32'h400, event_word_q);
    chk("still up", 1, proc_irq_q);
    idle;
    chan_mode = 8'hFF;
    cnt_cmp_hit = 4'hF;
    fire;
    chk("mode off", 0, proc_irq_q);
    chan_mode = 8'h55;
    ce = 1'b0;
    @(posedge clk) #1 cnt_cmp_hit = 4'h1;
    fire;
    chk("frozen", 0, proc_irq_q);
    ce = 1'b1;
    software_gate = 1'b0;
    hardware_gate = ~hardware_gate;
    fire;
    chk("gate shut", 0, proc_irq_q);
    @(posedge clk) #1 software_gate = 1'b1;
    for (i = 0; i < 300; i = i + 1)
    begin
      k = $unsigned($random(seed)) % 8;
      ch = k > 4 ? 3 : $unsigned($random(seed)) % (k == 0 ? 2 : 4);
      b = i < 100 ? 0 : $unsigned($random(seed)) % 8;
      chan_mode = k == 4 ? 8'hAA : k == 0 ? 8'h00 : 8'h55;
      lat = 4'(2 + $unsigned($random(seed)) % 4);
      case (k)
        0: alarm_in[ch*8+b] = ~alarm_in[ch*8+b];
        1: cnt_cmp_hit[ch] = 1'b1;
        2: cnt_overflow[ch] = 1'b1;
        3: cnt_underflow[ch] = 1'b1;
        4: meas_end[ch] = 1'b1;
        7: cnt3_latch_new = 1'b1;
        default: hardware_gate = ~hardware_gate;
      endcase
      fire;
      chk("word", expw(k, ch, b, hardware_gate), event_word_q);
      chk("base", 32'h1A2C, base_addr_q);
      idle;
    end
    report_and_stop;
  end
endmodule // io_process_interrupt_event_word_tb
`default_nettype wire
